// ### src/scan_access_port.sv
// Scan chain access port: register front end, queues, engine, mux
module scan_access_port (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Register transfers from the host port
  input scan_ap_pkg::acc_req_type acc_req,
  output logic acc_ack,
  output logic [31:0] acc_rdata,
  // Link clock for the scan engine
  input wire logic scan_clk,
  // Scan port pins
  output logic [7:0] tck,
  output logic [7:0] tms,
  output logic [7:0] tdi,
  output logic [7:0] trst_n,
  output logic [7:0] subsystem_reset_n,
  input wire logic [7:0] tdo,
  input wire logic [7:0] return_clock,
  input wire logic [7:0] port_present,
  input wire logic [7:0] port_active,
  input wire logic [7:0] subsystem_reset_present
);

  // Gray to binary for pointers crossing domains
  function automatic logic [3:0] g2b(input logic [3:0] g);
    logic [3:0] b;
    b[3] = g[3];
    for (int i = 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // ****************************************
  // System side state
  // ****************************************
  logic [2:0] ctrl_r, ctrl_nxt; // Pace, test reset, subsystem reset
  logic [7:0] sel_r, sel_nxt; // Port select
  logic ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [3:0] cq_wbin_r, cq_wbin_nxt, cq_wg_r;
  logic [3:0] rq_rbin_r, rq_rbin_nxt, rq_rg_r;
  logic [3:0] cq_rg_r_scan, rq_wg_r; // Gray pointers kept by the engine
  logic [3:0] cq_rg_s1, cq_rg_s2, rq_wg_s1, rq_wg_s2;
  logic [23:0] stat_s1, stat_s2; // Port status pins, synchronised
  logic [7:0] trst_n_r, srst_n_r;
  logic [7:0] cq_mem [8]; // Command bytes
  logic [7:0] rq_mem [8]; // Response bytes
  logic [3:0] cq_cnt, rq_cnt;
  logic [2:0] nbytes;
  logic is_cmd, is_rsp, take;

  assign cq_cnt = cq_wbin_r - g2b(cq_rg_s2);
  assign rq_cnt = g2b(rq_wg_s2) - rq_rbin_r;
  assign nbytes = {1'b0, acc_req.sel[1:0]} + 3'h1;
  assign is_cmd = acc_req.sel inside {[scan_ap_pkg::R_CMD1:
                                        scan_ap_pkg::R_CMD4]};
  assign is_rsp = acc_req.sel inside {[scan_ap_pkg::R_RSP1:
                                        scan_ap_pkg::R_RSP4]};

  // Decide whether the pending transfer completes this cycle
  always_comb begin
    take = acc_req.valid && !ack_r;
    if (is_cmd && acc_req.write) begin
      // Wait for room for every byte
      take = take && ((scan_ap_pkg::CQ_DEPTH - cq_cnt) >= {1'b0, nbytes});
    end else if (is_rsp && !acc_req.write) begin
      // Wait until all bytes are there
      take = take && (rq_cnt >= {1'b0, nbytes});
    end
  end

  // Register file next values
  always_comb begin
    ctrl_nxt = ctrl_r;
    sel_nxt = sel_r;
    ack_nxt = take;
    rdata_nxt = rdata_r;
    cq_wbin_nxt = cq_wbin_r;
    rq_rbin_nxt = rq_rbin_r;
    if (take) begin
      rdata_nxt = 32'h0;
      if (acc_req.sel == scan_ap_pkg::R_CTRL) begin
        if (acc_req.write) begin
          ctrl_nxt = acc_req.wdata[2:0];
        end
        rdata_nxt[2:0] = ctrl_r;
        rdata_nxt[scan_ap_pkg::CW_CCNT +: 4] = cq_cnt;
        rdata_nxt[scan_ap_pkg::CW_RCNT +: 4] = rq_cnt;
      end else if (acc_req.sel == scan_ap_pkg::R_SEL) begin
        if (acc_req.write) begin
          sel_nxt = acc_req.wdata[7:0];
        end
        rdata_nxt[7:0] = sel_r;
      end else if (acc_req.sel == scan_ap_pkg::R_STAT) begin
        rdata_nxt[23:0] = stat_s2;
      end else if (acc_req.sel == scan_ap_pkg::R_ID) begin
        rdata_nxt = scan_ap_pkg::ID_VALUE;
      end else if (is_cmd && acc_req.write) begin
        cq_wbin_nxt = cq_wbin_r + {1'b0, nbytes};
      end else if (is_rsp && !acc_req.write) begin
        // Lane 0 carries the oldest byte
        for (int i = 0; i < 4; i++) begin
          if (i < nbytes) begin
            rdata_nxt[8*i +: 8] = rq_mem[3'(rq_rbin_r[2:0] + 3'(i))];
          end
        end
        rq_rbin_nxt = rq_rbin_r + {1'b0, nbytes};
      end
    end
  end

  // System side registers
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl_r <= scan_ap_pkg::CW_RESET;
      sel_r <= scan_ap_pkg::SEL_RESET;
      ack_r <= 1'b0;
      rdata_r <= 32'h0;
      cq_wbin_r <= 4'h0;
      cq_wg_r <= 4'h0;
      rq_rbin_r <= 4'h0;
      rq_rg_r <= 4'h0;
      cq_rg_s1 <= 4'h0;
      cq_rg_s2 <= 4'h0;
      rq_wg_s1 <= 4'h0;
      rq_wg_s2 <= 4'h0;
      stat_s1 <= 24'h0;
      stat_s2 <= 24'h0;
      trst_n_r <= 8'hFF;
      srst_n_r <= 8'hFF;
    end else begin
      ctrl_r <= ctrl_nxt;
      sel_r <= sel_nxt;
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
      cq_wbin_r <= cq_wbin_nxt;
      cq_wg_r <= cq_wbin_nxt ^ (cq_wbin_nxt >> 1);
      rq_rbin_r <= rq_rbin_nxt;
      rq_rg_r <= rq_rbin_nxt ^ (rq_rbin_nxt >> 1);
      cq_rg_s1 <= cq_rg_r_scan;
      cq_rg_s2 <= cq_rg_s1;
      rq_wg_s1 <= rq_wg_r;
      rq_wg_s2 <= rq_wg_s1;
      // Present pins are tie-offs, still synchronised
      stat_s1 <= {subsystem_reset_present, port_present, port_active};
      stat_s2 <= stat_s1;
      // Active low reset pins
      trst_n_r <= {8{~ctrl_r[scan_ap_pkg::CW_TRST]}};
      srst_n_r <= {8{~ctrl_r[scan_ap_pkg::CW_SRST]}};
    end
  end

  // Command bytes land in the queue memory
  always_ff @(posedge clk_sys) begin
    if (take && is_cmd && acc_req.write) begin
      for (int i = 0; i < 4; i++) begin
        if (i < nbytes) begin
          cq_mem[3'(cq_wbin_r[2:0] + 3'(i))] <= acc_req.wdata[8*i +: 8];
        end
      end
    end
  end

  assign acc_ack = ack_r;
  assign acc_rdata = rdata_r;
  assign trst_n = trst_n_r;
  assign subsystem_reset_n = srst_n_r;

  // ****************************************
  // Scan engine on the link clock
  // ****************************************
  typedef enum logic [2:0] {
    E_IDLE = 3'b000, E_LEN = 3'b001, E_DATA = 3'b010,
    E_LOW = 3'b011, E_HIGH = 3'b100, E_PUSH = 3'b101
  } eng_state_type;

  eng_state_type st_r, st_nxt;
  logic [7:0] op_r, op_nxt; // Scan packet header
  logic [7:0] shf_r, shf_nxt; // Bits still to send
  logic [3:0] nbit_r, nbit_nxt; // Bits left in shf_r
  logic [7:0] len_r, len_nxt; // Clock cycles left
  logic tmsp_r, tmsp_nxt; // Mode select packet running
  logic tdih_r, tdih_nxt; // Held data in level
  logic [7:0] cap_r, cap_nxt;
  logic [2:0] capn_r, capn_nxt;
  logic tck_r, tck_nxt, tms_r, tms_nxt, tdi_r, tdi_nxt;
  logic [3:0] cq_rbin_r, cq_rbin_nxt;
  logic [3:0] rq_wbin_r, rq_wbin_nxt;
  logic [3:0] cq_wg_s1, cq_wg_s2, rq_rg_s1, rq_rg_s2;
  logic [7:0] sel_s1, sel_s2;
  logic pace_s1, pace_s2;
  // Every pin is synchronised before the select mask reads it
  logic [7:0] tdo_s1, tdo_s2, return_clock_s1, return_clock_s2;
  logic tdo_m, return_clock_m; // Selected ports merged
  logic [1:0] tck_d_r; // Driven clock delayed like a return
  logic [7:0] tck_o_r, tms_o_r, tdi_o_r;
  logic cq_empty, rq_full, return_clock_eff, last, need_data, capt, push;
  logic [7:0] cbyte;

  assign cq_empty = (cq_rbin_r == g2b(cq_wg_s2));
  assign rq_full = ((rq_wbin_r - g2b(rq_rg_s2)) == scan_ap_pkg::RQ_DEPTH);
  assign cbyte = cq_mem[cq_rbin_r[2:0]];
  assign tdo_m = |(tdo_s2 & sel_s2);
  assign return_clock_m = |(return_clock_s2 & sel_s2);
  // Without pacing the driven clock, delayed as far as the synchronised
  // data, stands in for the return so data out is not read stale
  assign return_clock_eff = pace_s2 ? return_clock_m : tck_d_r[1];
  assign last = (len_r == 8'h01);
  assign need_data = !tmsp_r && !op_r[0];
  assign capt = !tmsp_r && op_r[2];
  assign push = (st_r == E_PUSH) && !rq_full;

  // Engine next state
  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r;
    shf_nxt = shf_r;
    nbit_nxt = nbit_r;
    len_nxt = len_r;
    tmsp_nxt = tmsp_r;
    tdih_nxt = tdih_r;
    cap_nxt = cap_r;
    capn_nxt = capn_r;
    tck_nxt = tck_r;
    tms_nxt = tms_r;
    tdi_nxt = tdi_r;
    cq_rbin_nxt = cq_rbin_r;
    rq_wbin_nxt = rq_wbin_r;
    case (st_r)
      E_IDLE: begin
        if (!cq_empty) begin
          cq_rbin_nxt = cq_rbin_r + 4'h1;
          if (!cbyte[7]) begin
            tmsp_nxt = 1'b1;
            tdih_nxt = cbyte[6];
            shf_nxt = {3'h0, cbyte[4:0]};
            len_nxt = 8'h01;
            for (int i = 1; i < 6; i++) begin
              if (cbyte[i]) begin
                len_nxt = 8'(i);
              end
            end
            st_nxt = E_LOW;
          end else if (cbyte[6:5] == 2'b00) begin
            tmsp_nxt = 1'b0;
            op_nxt = cbyte;
            st_nxt = E_LEN;
          end
          // Reserved opcodes are dropped
        end
      end
      E_LEN: begin
        if (!cq_empty) begin
          cq_rbin_nxt = cq_rbin_r + 4'h1;
          len_nxt = {1'b0, cbyte[6:0]} + 8'h01;
          nbit_nxt = 4'h0;
          st_nxt = op_r[0] ? E_LOW : E_DATA;
        end
      end
      E_DATA: begin
        if (!cq_empty) begin
          cq_rbin_nxt = cq_rbin_r + 4'h1;
          shf_nxt = cbyte;
          nbit_nxt = 4'h8;
          st_nxt = E_LOW;
        end
      end
      E_LOW: begin
        // Set up the pins, then raise the clock
        tms_nxt = tmsp_r ? shf_r[0] : (last && op_r[3]);
        tdi_nxt = tmsp_r ? tdih_r : (op_r[0] ? op_r[1] : shf_r[0]);
        // Raise only once mode and data already stand at the pins
        if (!return_clock_eff && !tck_r && tms_r == tms_nxt &&
            tdi_r == tdi_nxt) begin
          tck_nxt = 1'b1;
          st_nxt = E_HIGH;
        end
      end
      E_HIGH: begin
        if (return_clock_eff) begin
          tck_nxt = 1'b0;
          shf_nxt = shf_r >> 1;
          nbit_nxt = nbit_r - 4'h1;
          len_nxt = len_r - 8'h01;
          if (capt) begin
            cap_nxt = cap_r | (8'(tdo_m) << capn_r);
            capn_nxt = capn_r + 3'h1;
          end
          if (capt && (capn_r == 3'h7 || last)) begin
            st_nxt = E_PUSH;
          end else if (last) begin
            st_nxt = E_IDLE;
          end else if (need_data && nbit_r == 4'h1) begin
            st_nxt = E_DATA;
          end else begin
            st_nxt = E_LOW;
          end
        end
      end
      E_PUSH: begin
        // Stall the scan while the response queue is full
        if (!rq_full) begin
          rq_wbin_nxt = rq_wbin_r + 4'h1;
          cap_nxt = 8'h00;
          capn_nxt = 3'h0;
          if (len_r == 8'h00) begin
            st_nxt = E_IDLE;
          end else begin
            st_nxt = (need_data && nbit_r == 4'h0) ? E_DATA : E_LOW;
          end
        end
      end
      default: st_nxt = E_IDLE;
    endcase
  end

  // Engine registers, crossings and port pins
  always_ff @(posedge scan_clk or posedge reset) begin
    if (reset) begin
      st_r <= E_IDLE;
      op_r <= 8'h00;
      shf_r <= 8'h00;
      nbit_r <= 4'h0;
      len_r <= 8'h00;
      tmsp_r <= 1'b0;
      tdih_r <= 1'b0;
      cap_r <= 8'h00;
      capn_r <= 3'h0;
      tck_r <= 1'b0;
      tms_r <= 1'b0;
      tdi_r <= 1'b0;
      cq_rbin_r <= 4'h0;
      cq_rg_r_scan <= 4'h0;
      rq_wbin_r <= 4'h0;
      rq_wg_r <= 4'h0;
      cq_wg_s1 <= 4'h0;
      cq_wg_s2 <= 4'h0;
      rq_rg_s1 <= 4'h0;
      rq_rg_s2 <= 4'h0;
      sel_s1 <= 8'h00;
      sel_s2 <= 8'h00;
      pace_s1 <= 1'b0;
      pace_s2 <= 1'b0;
      tdo_s1 <= 8'h00;
      tdo_s2 <= 8'h00;
      return_clock_s1 <= 8'h00;
      return_clock_s2 <= 8'h00;
      tck_d_r <= 2'h0;
      tck_o_r <= 8'h00;
      tms_o_r <= 8'h00;
      tdi_o_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      shf_r <= shf_nxt;
      nbit_r <= nbit_nxt;
      len_r <= len_nxt;
      tmsp_r <= tmsp_nxt;
      tdih_r <= tdih_nxt;
      cap_r <= cap_nxt;
      capn_r <= capn_nxt;
      tck_r <= tck_nxt;
      tms_r <= tms_nxt;
      tdi_r <= tdi_nxt;
      cq_rbin_r <= cq_rbin_nxt;
      cq_rg_r_scan <= cq_rbin_nxt ^ (cq_rbin_nxt >> 1);
      rq_wbin_r <= rq_wbin_nxt;
      rq_wg_r <= rq_wbin_nxt ^ (rq_wbin_nxt >> 1);
      cq_wg_s1 <= cq_wg_r;
      cq_wg_s2 <= cq_wg_s1;
      rq_rg_s1 <= rq_rg_r;
      rq_rg_s2 <= rq_rg_s1;
      sel_s1 <= sel_r;
      sel_s2 <= sel_s1;
      pace_s1 <= ctrl_r[scan_ap_pkg::CW_PACE];
      pace_s2 <= pace_s1;
      // Pins first, selected ports merge after the second stage
      tdo_s1 <= tdo;
      tdo_s2 <= tdo_s1;
      return_clock_s1 <= return_clock;
      return_clock_s2 <= return_clock_s1;
      tck_d_r <= {tck_d_r[0], tck_r};
      // Broadcast to every selected port
      tck_o_r <= {8{tck_nxt}} & sel_s2;
      tms_o_r <= {8{tms_nxt}} & sel_s2;
      tdi_o_r <= {8{tdi_nxt}} & sel_s2;
    end
  end

  // Response bytes land in the queue memory
  always_ff @(posedge scan_clk) begin
    if (push) begin
      rq_mem[rq_wbin_r[2:0]] <= cap_r;
    end
  end

  assign tck = tck_o_r;
  assign tms = tms_o_r;
  assign tdi = tdi_o_r;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_rsp_take;
    acc_req.valid && !ack_r && is_rsp && !acc_req.write;
  endsequence
  sequence s_cmd_take;
    acc_req.valid && !ack_r && is_cmd && acc_req.write;
  endsequence

  chk_ctrl_ack_fixed: assert property (@(posedge clk_sys) disable iff (reset)
    acc_req.valid && !ack_r && !is_cmd && !is_rsp |=> ack_r)
    else $error("control access not answered next cycle");
  chk_rsp_stall_count: assert property (@(posedge clk_sys)
    disable iff (reset) s_rsp_take ##1 ack_r |->
    $past(rq_cnt) >= {1'b0, $past(nbytes)})
    else $error("response read answered without enough bytes");
  chk_cmd_stall_room: assert property (@(posedge clk_sys)
    disable iff (reset) s_cmd_take ##1 ack_r |->
    $past(cq_cnt) + {1'b0, $past(nbytes)} <= scan_ap_pkg::CQ_DEPTH)
    else $error("command write answered without room");
  chk_rq_depth_bound: assert property (@(posedge clk_sys)
    disable iff (reset) rq_cnt <= scan_ap_pkg::RQ_DEPTH)
    else $error("response queue above seven bytes");
  chk_cq_depth_bound: assert property (@(posedge clk_sys)
    disable iff (reset) cq_cnt <= scan_ap_pkg::CQ_DEPTH)
    else $error("command queue above seven bytes");
  chk_trst_follow: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(ctrl_r[scan_ap_pkg::CW_TRST]) |=> trst_n == 8'h00)
    else $error("test reset pins did not follow control");
  chk_tck_paced: assert property (@(posedge scan_clk) disable iff (reset)
    st_r == E_HIGH && !return_clock_eff |=> tck_r)
    else $error("clock dropped before return clock");
  chk_reserved_drop: assert property (@(posedge scan_clk)
    disable iff (reset) st_r == E_IDLE && !cq_empty && cbyte[7] &&
    cbyte[6:5] != 2'b00 |=> st_r == E_IDLE)
    else $error("reserved opcode started a packet");

endmodule // scan_access_port

// ### src/scan_ap_pkg.sv
// Constants and types shared by the scan chain access port
// How it works
// - One to eight scan chains per access port
// - Host port transfers reach the access port
// - Engine pops command bytes, drives test signals
// - Multiplexer routes eight ports to one engine
// - Scan side asynchronous, paced by return clock
// - Response queue holds exactly seven bytes
// - Command queue holds exactly seven bytes
// - Control, select, status, id answer at once
// - Queue register accesses may stall
// - Response read n stalls until n bytes
// - Command write n stalls until n free
// - Control word shows response byte count
// - Control word shows queued command byte count
// - Reset pins follow the two control bits
// - Per port clock, mode, data, reset out
// - Per port active low subsystem reset out
// - Return clock synthesized when none exists
// - Opcode by upper bits, others reserved
package scan_ap_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NPORT = 8;
  localparam logic [3:0] CQ_DEPTH = 4'h7;
  localparam logic [3:0] RQ_DEPTH = 4'h7;

  // ****************************************
  // Control word fields and reset values
  // ****************************************
  localparam int CW_SRST = 0;
  localparam int CW_TRST = 1;
  localparam int CW_PACE = 2;
  localparam int CW_CCNT = 4;
  localparam int CW_RCNT = 8;
  localparam logic [2:0] CW_RESET = 3'h0;
  localparam logic [7:0] SEL_RESET = 8'h00;
  // Identification value is arbitrary
  localparam logic [31:0] ID_VALUE = 32'h00A5_5A01;

  // Register selector
  typedef enum logic [3:0] {
    R_CTRL = 4'h0, R_SEL = 4'h1, R_STAT = 4'h2, R_ID = 4'h3,
    R_CMD1 = 4'h4, R_CMD2 = 4'h5, R_CMD3 = 4'h6, R_CMD4 = 4'h7,
    R_RSP1 = 4'h8, R_RSP2 = 4'h9, R_RSP3 = 4'hA, R_RSP4 = 4'hB
  } reg_sel_type;

  // One register transfer from the host port
  typedef struct packed {
    logic valid;
    logic write;
    reg_sel_type sel;
    logic [31:0] wdata;
  } acc_req_type;

endpackage

// ### verif/scan_target_model.sv
// Behavioural scan target on one port: one-bit bypass with return clock
module scan_target_model (
  // Test signals from the multiplexer
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  // Signals back to the multiplexer
  output logic tdo,
  output logic return_clock
);
  timeunit 1ns;
  timeprecision 100ps;

  logic bypass_r; // Single test port on this chain
  logic [1:0] seen_q[$]; // Log of {mode, data in} at each rising clock

  // Start from a known shift stage
  initial begin
    bypass_r = 1'b0;
    tdo = 1'b0;
  end

  // Capture data in and log pins on the rising test clock
  always @(posedge tck) begin
    bypass_r <= tdi;
    seen_q.push_back({tms, tdi});
  end

  // Launch on falling clock, as a real target does, not kinder
  always @(negedge tck) begin
    tdo <= bypass_r;
  end

  // Echo with delay so the pacing really waits for it
  assign #30 return_clock = tck;
endmodule // scan_target_model

// ### verif/testbench.sv
// Self-checking bench for the scan chain access port
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // Clocks, pins and counters
  // ****************************************
  logic clk_sys; // System clock, 50 ns
  logic scan_clk; // Link clock, 125 ns
  logic reset; // Active high reset
  scan_ap_pkg::acc_req_type acc_req; // Host transfer request
  logic acc_ack;
  logic [31:0] acc_rdata;
  logic [7:0] tck, tms, tdi, trst_n, subsystem_reset_n;
  logic [7:0] port_present, port_active, subsystem_reset_present;
  logic t_tdo; // Target data out on port 0
  logic t_rclk; // Target return clock on port 0
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [31:0] q; // Last read data
  int lat; // Cycles from request to answer
  logic [15:0] d; // Random payload

  scan_access_port DUT (
    .clk_sys(clk_sys), .reset(reset), .acc_req(acc_req),
    .acc_ack(acc_ack), .acc_rdata(acc_rdata), .scan_clk(scan_clk),
    .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
    .subsystem_reset_n(subsystem_reset_n), .tdo({7'h00, t_tdo}),
    .return_clock({7'h00, t_rclk}), .port_present(port_present),
    .port_active(port_active),
    .subsystem_reset_present(subsystem_reset_present)
  );

  scan_target_model u_target (
    .tck(tck[0]), .tms(tms[0]), .tdi(tdi[0]),
    .tdo(t_tdo), .return_clock(t_rclk)
  );

  // Two unrelated clocks
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    scan_clk = 1'b0;
    #17;
    forever #62.5 scan_clk = ~scan_clk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One transfer: hold request until the ack edge, then release
  task automatic acc(input logic w, input logic [3:0] s,
                     input logic [31:0] wd);
    @(posedge clk_sys);
    acc_req <= '{1'b1, w, scan_ap_pkg::reg_sel_type'(s), wd};
    lat = 0;
    do begin
      @(posedge clk_sys);
      lat++;
    end while (acc_ack !== 1'b1 && lat < 3000);
    // A stall that outlives the limit counts against the run
    if (acc_ack !== 1'b1) mismatches++;
    q = acc_rdata;
    acc_req.valid <= 1'b0;
  endtask

  // Hang guard well above the planned run
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches++;
      conclude();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32'he486));
    reset = 1'b1;
    acc_req = '0;
    port_present = 8'($urandom); // Static tie-offs
    subsystem_reset_present = 8'($urandom);
    port_active = 8'($urandom);
    repeat (8) @(posedge clk_sys);
    chk({16'h0, trst_n, subsystem_reset_n}, 32'hFFFF);
    reset <= 1'b0;
    // Identification answers at once
    acc(1'b0, 4'h3, 32'h0);
    chk(q, scan_ap_pkg::ID_VALUE);
    chk(32'(lat), 32'h2);
    // Both reset bits low-drive all ports, then release with pacing on
    acc(1'b1, 4'h0, 32'h3);
    repeat (3) @(posedge clk_sys);
    chk({trst_n, subsystem_reset_n}, 32'h0);
    acc(1'b1, 4'h0, 32'h4);
    repeat (3) @(posedge clk_sys);
    chk({trst_n, subsystem_reset_n}, 32'hFFFF);
    // Status follows per-port inputs, active may drop any time
    repeat (4) @(posedge clk_sys);
    acc(1'b0, 4'h2, 32'h0);
    chk(q, {8'h0, subsystem_reset_present, port_present,
            port_active});
    port_active <= 8'($urandom);
    repeat (6) @(posedge clk_sys);
    acc(1'b0, 4'h2, 32'h0);
    chk(q, {8'h0, subsystem_reset_present, port_present,
            port_active});
    // Select readback, then port 0 only
    d = 16'($urandom);
    acc(1'b1, 4'h1, {24'h0, d[7:0]});
    acc(1'b0, 4'h1, 32'h0);
    chk(q, {24'h0, d[7:0]});
    acc(1'b1, 4'h1, 32'h1);
    // Reserved byte dropped, mode packet 1,0,1 with data in high
    acc(1'b1, 4'h5, 32'h4DA0);
    repeat (300) @(posedge clk_sys);
    chk(u_target.seen_q.size(), 32'h3);
    for (int i = 0; i < 3; i++)
      chk(u_target.seen_q[i], {30'h0, 1'(i != 1), 1'b1});
    u_target.seen_q.delete();
    // Sixteen-bit captured scan, header in the oldest lane
    d = 16'($urandom);
    acc(1'b1, 4'h7, {d, 8'h0F, 8'h84});
    acc(1'b0, 4'h8, 32'h0);
    chk(32'(lat > 20), 32'h1);
    chk(q, {24'h0, d[6:0], 1'b1});
    repeat (600) @(posedge clk_sys);
    acc(1'b0, 4'h0, 32'h0);
    chk(q, 32'h104);
    acc(1'b0, 4'h8, 32'h0);
    chk(32'(lat), 32'h2);
    chk(q, {24'h0, d[14:7]});
    chk(u_target.seen_q.size(), 32'h10);
    for (int i = 0; i < 16; i++)
      chk(u_target.seen_q[i], {31'h0, d[i]});
    u_target.seen_q.delete();
    // Three four-byte writes: the last must wait for room
    for (int k = 0; k < 3; k++)
      acc(1'b1, 4'h7, 32'h3F3F3F3F);
    chk(32'(lat > 20), 32'h1);
    repeat (2000) @(posedge clk_sys);
    acc(1'b0, 4'h0, 32'h0);
    chk(q, 32'h4);
    chk(u_target.seen_q.size(), 32'd60);
    for (int i = 0; i < 60; i++)
      chk(u_target.seen_q[i], 32'h2);
    chk({24'h0, tck}, 32'h0);
    // Test reset held, pacing off: two clocks with mode high, then a
    // four-bit capture at a fixed low data level
    u_target.seen_q.delete();
    acc(1'b1, 4'h0, 32'h2);
    acc(1'b1, 4'h6, 32'h00038547);
    acc(1'b0, 4'h8, 32'h0);
    chk(q, 32'h01);
    chk(u_target.seen_q.size(), 32'h6);
    for (int i = 0; i < 6; i++)
      chk(u_target.seen_q[i], (i < 2) ? 32'h3 : 32'h0);
    chk({16'h0, trst_n, subsystem_reset_n}, 32'h00FF);
    conclude();
  end
endmodule // testbench
